//--- verilog/dmd_pkg.sv
// Constants and types shared by the data-memory decoder and its bus engine.
// Assumes a single core clock; no other package is needed.
package dmd_pkg;

  // On-chip data storage: 256 B internal plus 768 B expanded, 1024 B in all
  localparam int unsigned INT_RAM_BYTES = 256;
  localparam int unsigned EXPANDED_DATA_RAM_BYTES    = 768;
  localparam int unsigned ONCHIP_BYTES  = INT_RAM_BYTES + EXPANDED_DATA_RAM_BYTES;
  localparam int unsigned EXT_ADDR_BITS = 16; // 64 kB external space

  // Address boundaries
  localparam logic [7:0]  LOWER_LAST      = 8'h7f;
  localparam logic [15:0] EXPANDED_DATA_RAM_LAST       = 16'h02ff;
  localparam logic [15:0] EXT_FIRST       = 16'h0300;
  localparam logic [15:0] INDEX_EXPANDED_DATA_RAM_LAST = 16'h00ff;

  // Auxiliary memory control register
  localparam logic [7:0] AUX_ADDR       = 8'h8e;
  localparam logic [7:0] AUX_RESET      = 8'h00;
  localparam logic [7:0] AUX_WR_MASK    = 8'h03;
  localparam int         ROUTE_BIT      = 1;
  localparam int         STROBE_OFF_BIT = 0;

  // Read or write strobe width on the external bus, in clocks
  localparam logic [3:0] BUS_STROBE_CYCLES = 4'h2;

  typedef enum logic [2:0] {
    ACC_DIRECT,
    ACC_INDIRECT,
    ACC_STACK,
    ACC_EXT_INDEX,
    ACC_EXT_POINTER
  } access_kind_t;

  typedef enum logic [2:0] {
    TGT_LOWER,
    TGT_UPPER,
    TGT_SFR_AUX,
    TGT_SFR_OTHER,
    TGT_EXPANDED_DATA_RAM,
    TGT_EXT
  } target_t;

endpackage

//--- verilog/ext_bus_if.sv
// Request and answer path between the decoder and the external bus engine.
// Both ends run on the same core clock.
`timescale 1ns/1ps
interface ext_bus_if;
  logic        start;
  logic        wide;
  logic        write;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  logic        busy;

  modport ctrl (output start, output wide, output write, output addr, output wdata,
                input done, input rdata, input busy);
  modport eng  (input start, input wide, input write, input addr, input wdata,
                output done, output rdata, output busy);
endinterface

//--- verilog/ext_bus_engine.sv
// Multiplexed address/data bus sequencer for external data moves.
// Assumes port 0 pin level arrives synchronous to clk on p0_in.
`timescale 1ns/1ps
module ext_bus_engine
  import dmd_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  sys_rst,
  ext_bus_if.eng     bus,
  output logic [7:0] p0_out,
  output logic       p0_oe,
  input  wire logic [7:0] p0_in,
  output logic [7:0] p2_out,
  output logic       p2_oe,
  output logic       rd_n,
  output logic       wr_n
);

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_SETUP, ST_STROBE} eng_state_t;

  typedef struct packed {
    eng_state_t st;
    logic [3:0] cnt;
    logic [7:0] p0;
    logic       p0_oe;
    logic [7:0] p2;
    logic       p2_oe;
    logic       rd_n;
    logic       wr_n;
    logic       write;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       done;
  } eng_t;

  eng_t s_q;
  eng_t s_d;

  // Address phase, latch, then strobe; pins are released at the end
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (bus.start) begin
          s_d.p0    = bus.addr[7:0];
          s_d.p0_oe = 1'b1;
          s_d.p2    = bus.addr[15:8];
          s_d.p2_oe = bus.wide;                       // Byte index leaves port 2 to software
          s_d.write = bus.write;
          s_d.wdata = bus.wdata;
          s_d.st    = ST_ADDR;
        end
      end
      ST_ADDR: begin
        s_d.p0_oe = s_q.write;                        // Turn port 0 round for reads
        s_d.p0    = s_q.wdata;
        s_d.st    = ST_SETUP;
      end
      ST_SETUP: begin
        s_d.rd_n = s_q.write;
        s_d.wr_n = ~s_q.write;
        s_d.cnt  = BUS_STROBE_CYCLES - 4'h1;
        s_d.st   = ST_STROBE;
      end
      ST_STROBE: begin
        if (s_q.cnt == 4'h0) begin
          if (!s_q.write) begin
            s_d.rdata = p0_in;
          end
          s_d.rd_n  = 1'b1;
          s_d.wr_n  = 1'b1;
          s_d.p0_oe = 1'b0;
          s_d.p2_oe = 1'b0;
          s_d.done  = 1'b1;
          s_d.st    = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '{st: ST_IDLE, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign p0_out    = s_q.p0;
  assign p0_oe     = s_q.p0_oe;
  assign p2_out    = s_q.p2;
  assign p2_oe     = s_q.p2_oe;
  assign rd_n      = s_q.rd_n;
  assign wr_n      = s_q.wr_n;
  assign bus.done  = s_q.done;
  assign bus.rdata = s_q.rdata;
  assign bus.busy  = (s_q.st != ST_IDLE);

endmodule

//--- verilog/data_memory_decoder.sv
// Data-memory decoder: steers each core data access to internal RAM,
// the auxiliary control register, other special function registers,
// expanded RAM or the external multiplexed bus.
// Assumes the core holds a request until ready and that clk is the oscillator.
`timescale 1ns/1ps
module data_memory_decoder
  import dmd_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Core request
  input  wire logic                  req_valid,
  input  wire dmd_pkg::access_kind_t req_kind,
  input  wire logic [15:0]           req_addr,
  input  wire logic                  req_write,
  input  wire logic [7:0]            req_wdata,
  output logic                       req_ready,
  output logic                       resp_valid,
  output logic [7:0]                 resp_rdata,
  // Code-move fetch in progress elsewhere in the core
  input  wire logic                  code_move_active,
  // Other special function registers, kept by the core
  output logic                       sfr_valid,
  output logic                       sfr_write,
  output logic [7:0]                 sfr_addr,
  output logic [7:0]                 sfr_wdata,
  input  wire logic [7:0]            sfr_rdata,
  // Control register contents for the rest of the core
  output logic [7:0]                 aux_memory_control,
  // External bus pins
  output logic [7:0]                 p0_out,
  output logic                       p0_oe,
  input  wire logic [7:0]            p0_in,
  output logic [7:0]                 p2_out,
  output logic                       p2_oe,
  output logic                       rd_n,
  output logic                       wr_n,
  output logic                       latch_strobe
);

  typedef struct packed {
    logic [7:0] aux;
    logic       resp_valid;
    logic [7:0] rdata;
    logic       ext_wait;
    logic       sfr_wait;
    logic       sfr_valid;
    logic       sfr_write;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       ale_phase;
    logic       ale;
  } dec_t;

  dec_t s_q;
  dec_t s_d;

  // Internal RAM holds lower and upper halves; registers live elsewhere
  logic [7:0] int_ram [0:INT_RAM_BYTES-1];
  logic [7:0] expanded_data_ram    [0:EXPANDED_DATA_RAM_BYTES-1];

  logic       int_we;
  logic       expanded_data_ram_we;
  logic [9:0] expanded_data_ram_idx;
  logic       route_ext;
  logic       strobe_off;
  logic       accept;
  target_t    tgt;

  ext_bus_if bus ();

  // Chooses the target of one access
  function automatic target_t decode_target(input access_kind_t kind,
                                            input logic [15:0]  addr,
                                            input logic         route);
    target_t t;
    t = TGT_LOWER;
    case (kind)
      ACC_DIRECT: begin
        if (addr[7:0] <= LOWER_LAST) begin
          t = TGT_LOWER;
        end else if (addr[7:0] == AUX_ADDR) begin
          t = TGT_SFR_AUX;
        end else begin
          t = TGT_SFR_OTHER;
        end
      end
      // Stack only ever lands in the 256 B internal RAM
      ACC_INDIRECT, ACC_STACK: begin
        t = addr[7] ? TGT_UPPER : TGT_LOWER;
      end
      ACC_EXT_INDEX: begin
        t = route ? TGT_EXT : TGT_EXPANDED_DATA_RAM;
      end
      ACC_EXT_POINTER: begin
        if (!route && addr <= EXPANDED_DATA_RAM_LAST) begin
          t = TGT_EXPANDED_DATA_RAM;
        end else begin
          t = TGT_EXT;
        end
      end
      default: t = TGT_LOWER;
    endcase
    return t;
  endfunction

  assign route_ext  = s_q.aux[ROUTE_BIT];
  assign strobe_off = s_q.aux[STROBE_OFF_BIT];
  assign tgt        = decode_target(req_kind, req_addr, route_ext);

  // One access in flight; slow targets hold ready low until answered
  assign req_ready = ~(s_q.ext_wait | s_q.sfr_wait | s_q.sfr_valid);
  assign accept    = req_valid & req_ready;

  // Byte index reaches only the first 256 B of expanded RAM
  assign expanded_data_ram_idx = (req_kind == ACC_EXT_INDEX) ? {2'b00, req_addr[7:0]} : req_addr[9:0];

  // Bus engine request, raised in the accept cycle
  assign bus.start = accept && (tgt == TGT_EXT);
  assign bus.wide  = (req_kind == ACC_EXT_POINTER);
  assign bus.write = req_write;
  assign bus.addr  = req_addr;
  assign bus.wdata = req_wdata;

  // Decode, register accesses and answer path
  always_comb begin
    s_d            = s_q;
    s_d.resp_valid = 1'b0;
    s_d.sfr_valid  = 1'b0;
    s_d.ale_phase  = ~s_q.ale_phase;
    int_we         = 1'b0;
    expanded_data_ram_we        = 1'b0;
    if (accept) begin
      case (tgt)
        TGT_LOWER, TGT_UPPER: begin
          int_we         = req_write;
          s_d.rdata      = int_ram[req_addr[7:0]];
          s_d.resp_valid = 1'b1;
        end
        TGT_SFR_AUX: begin
          if (req_write) begin
            s_d.aux = req_wdata & AUX_WR_MASK;   // Reserved bits stay zero
          end
          s_d.rdata      = s_q.aux;
          s_d.resp_valid = 1'b1;
        end
        TGT_SFR_OTHER: begin
          s_d.sfr_valid = 1'b1;
          s_d.sfr_write = req_write;
          s_d.sfr_addr  = req_addr[7:0];
          s_d.sfr_wdata = req_wdata;
          s_d.sfr_wait  = 1'b1;
        end
        // No pin moves for an expanded RAM access
        TGT_EXPANDED_DATA_RAM: begin
          expanded_data_ram_we        = req_write;
          s_d.rdata      = expanded_data_ram[expanded_data_ram_idx];
          s_d.resp_valid = 1'b1;
        end
        TGT_EXT: begin
          s_d.ext_wait = 1'b1;
        end
        default: s_d.resp_valid = 1'b0;
      endcase
    end
    // Register block answers one cycle after it sees the strobe
    if (s_q.sfr_wait && !s_q.sfr_valid) begin
      s_d.rdata      = sfr_rdata;
      s_d.resp_valid = 1'b1;
      s_d.sfr_wait   = 1'b0;
    end
    if (s_q.ext_wait && bus.done) begin
      s_d.rdata      = bus.rdata;
      s_d.resp_valid = 1'b1;
      s_d.ext_wait   = 1'b0;
    end
    // Latch strobe: free running at half rate, or only during moves.
    // Low while the engine works, so it never overlaps data on port 0;
    // the one address pulse comes from the start request below.
    if (bus.busy) begin
      s_d.ale = 1'b0;
    end else if (!strobe_off) begin
      s_d.ale = s_d.ale_phase;
    end else begin
      s_d.ale = code_move_active & s_d.ale_phase;
    end
    if (bus.start) begin
      s_d.ale = 1'b1;                                      // Address phase is always latched
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.aux <= AUX_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // RAM contents survive reset, so the arrays take no reset branch
  always_ff @(posedge clk) begin
    if (int_we) begin
      int_ram[req_addr[7:0]] <= req_wdata;
    end
    if (expanded_data_ram_we) begin
      expanded_data_ram[expanded_data_ram_idx] <= req_wdata;
    end
  end

  ext_bus_engine u_engine (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bus     (bus.eng),
    .p0_out  (p0_out),
    .p0_oe   (p0_oe),
    .p0_in   (p0_in),
    .p2_out  (p2_out),
    .p2_oe   (p2_oe),
    .rd_n    (rd_n),
    .wr_n    (wr_n)
  );

  assign resp_valid         = s_q.resp_valid;
  assign resp_rdata         = s_q.rdata;
  assign sfr_valid          = s_q.sfr_valid;
  assign sfr_write          = s_q.sfr_write;
  assign sfr_addr           = s_q.sfr_addr;
  assign sfr_wdata          = s_q.sfr_wdata;
  assign aux_memory_control = s_q.aux;
  assign latch_strobe       = s_q.ale;

endmodule

//--- test/data_memory_decoder_properties.sv
// Port-level checks for the data-memory decoder.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module data_memory_decoder_properties
  import dmd_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  req_valid,
  input wire dmd_pkg::access_kind_t req_kind,
  input wire logic [15:0]           req_addr,
  input wire logic                  req_write,
  input wire logic                  req_ready,
  input wire logic                  resp_valid,
  input wire logic                  sfr_valid,
  input wire logic [7:0]            sfr_addr,
  input wire logic [7:0]            aux_memory_control,
  input wire logic [7:0]            p0_out,
  input wire logic                  p0_oe,
  input wire logic [7:0]            p2_out,
  input wire logic                  p2_oe,
  input wire logic                  rd_n,
  input wire logic                  wr_n,
  input wire logic                  latch_strobe,
  input wire logic                  code_move_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Bus idle and no code move: strobe has no reason to run
  logic quiet;
  assign quiet = rd_n && wr_n && !p0_oe && !code_move_active;

  chk_sfr_cause:
    assert property (sfr_valid |-> sfr_addr[7] && sfr_addr != AUX_ADDR && $past(req_valid && req_ready
      && req_kind == ACC_DIRECT && req_addr[7]) && sfr_addr == $past(req_addr[7:0]))
    else $error("register access without a direct cause");
  chk_sfr_answer:
    assert property (sfr_valid |-> !req_ready ##1 !req_ready ##1 resp_valid) else $error("register answer late");
  chk_latch_drop:
    assert property ($rose(p0_oe) |=> !latch_strobe) else $error("latch strobe overlaps data phase");
  chk_ext_addr:
    assert property ($rose(p0_oe) |-> latch_strobe && p0_out == $past(req_addr[7:0])
      && p2_oe == ($past(req_kind) == ACC_EXT_POINTER) && (!p2_oe || p2_out == $past(req_addr[15:8])))
    else $error("external address phase wrong");
  chk_strobe_cause:
    assert property ($fell(rd_n) || $fell(wr_n) |-> ($past(aux_memory_control[1], 3)
      || $past(req_kind, 3) == ACC_EXT_POINTER && $past(req_addr, 3) >= EXT_FIRST)
      && $fell(wr_n) == $past(req_write, 3)) else $error("strobe without external target");
  chk_strobe_width:
    assert property ($fell(rd_n) |=> !rd_n ##1 (rd_n && !p0_oe)) else $error("read strobe width");
  chk_ext_answer:
    assert property ($rose(rd_n) || $rose(wr_n) |=> resp_valid) else $error("external answer late");
  chk_expanded_data_ram_quiet:
    assert property (req_valid && req_ready && !aux_memory_control[1] && (req_kind == ACC_EXT_INDEX
      || req_kind == ACC_EXT_POINTER && req_addr <= EXPANDED_DATA_RAM_LAST) |=> (!p0_oe && !p2_oe && rd_n && wr_n) [*2])
    else $error("expanded RAM access moved pins");
  chk_strobe_off:
    assert property (aux_memory_control[0] && $past(aux_memory_control[0]) && quiet && $past(quiet)
      |-> !latch_strobe) else $error("latch strobe ran while off");
  chk_aux_reserved:
    assert property (aux_memory_control[7:2] == 6'h00) else $error("reserved control bits set");
  chk_strobe_pair:
    assert property (!rd_n |-> wr_n) else $error("both strobes low");
endmodule

bind data_memory_decoder data_memory_decoder_properties chk (.clk(clk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_write(req_write),
  .req_ready(req_ready), .resp_valid(resp_valid), .sfr_valid(sfr_valid), .sfr_addr(sfr_addr),
  .aux_memory_control(aux_memory_control), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out),
  .p2_oe(p2_oe), .rd_n(rd_n), .wr_n(wr_n), .latch_strobe(latch_strobe),
  .code_move_active(code_move_active));

//--- test/ext_mem_model.sv
// Behavioural external data memory on the multiplexed bus.
// Assumes the address is latched while latch_strobe is high and port 0 drives.
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic       clk,
  input  wire logic [7:0] p0_out,
  input  wire logic       p0_oe,
  input  wire logic [7:0] p2_out,
  input  wire logic       p2_oe,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       latch_strobe,
  output logic      [7:0] p0_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q = 16'h0000;
  logic [7:0]  last_q = 8'h00;
  // Released port 0 outside a read strobe shows the inverse of its last level, never a stale value
  assign p0_in = p0_oe ? p0_out : (!rd_n ? mem[addr_q] : ~last_q);
  // Page bits come from port 2 only on pointer moves
  always @(posedge clk) begin
    last_q <= p0_in;
    if (latch_strobe && p0_oe) addr_q <= {p2_oe ? p2_out : 8'h00, p0_out};
    if (!wr_n) mem[addr_q] <= p0_out;
  end
endmodule

//--- test/data_memory_decoder_bench.sv
// Self-checking bench for the data-memory decoder and an external memory.
// Assumes 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module data_memory_decoder_bench;
  import dmd_pkg::*;
  logic         clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, code_move_active = 1'b0;
  access_kind_t req_kind = ACC_DIRECT;
  logic [15:0]  req_addr = 16'h0000;
  logic [7:0]   req_wdata = 8'h00, sfr_rdata = 8'h00, rd;
  logic         req_ready, resp_valid, sfr_valid, sfr_write, p0_oe, p2_oe, rd_n, wr_n, latch_strobe, l;
  logic [7:0]   resp_rdata, sfr_addr, sfr_wdata, aux_memory_control, p0_out, p0_in, p2_out;
  int           err_count = 0;
  int           num_checks = 0;

  data_memory_decoder DUT (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_write(req_write), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .code_move_active(code_move_active),
    .sfr_valid(sfr_valid), .sfr_write(sfr_write), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .aux_memory_control(aux_memory_control), .p0_out(p0_out), .p0_oe(p0_oe),
    .p0_in(p0_in), .p2_out(p2_out), .p2_oe(p2_oe), .rd_n(rd_n), .wr_n(wr_n), .latch_strobe(latch_strobe));
  ext_mem_model mem_model (.clk(clk), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p2_oe(p2_oe),
    .rd_n(rd_n), .wr_n(wr_n), .latch_strobe(latch_strobe), .p0_in(p0_in));

  initial begin
    forever #5 clk = ~clk;
  end
  // Core registers answer with a pattern derived from their address
  always @(negedge clk) sfr_rdata <= sfr_addr ^ 8'h5a;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access: held until taken, then wait a bounded time for its answer
  task automatic acc(input access_kind_t k, input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_write = w;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("mismatch at %0t: no answer to request", $time);
    end
    rd = resp_rdata;
  endtask
  task automatic rdc(input access_kind_t k, input logic [15:0] a, input logic [7:0] exp);
    acc(k, a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask
  // Strobe must flip on the next clock
  task automatic toggles;
    @(negedge clk);
    l = latch_strobe;
    @(negedge clk);
    chk({7'h00, latch_strobe}, {7'h00, ~l});
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    chk({5'h00, rd_n, wr_n, p0_oe}, 8'h06);
    rdc(ACC_DIRECT, 16'h008e, 8'h00);
    repeat (3) toggles;
    acc(ACC_DIRECT, 16'h0010, 1'b1, 8'ha1);
    rdc(ACC_INDIRECT, 16'h0010, 8'ha1);
    acc(ACC_INDIRECT, 16'h0090, 1'b1, 8'h3c);
    rdc(ACC_DIRECT, 16'h0090, 8'hca);
    acc(ACC_DIRECT, 16'h0090, 1'b1, 8'h5c);
    chk(sfr_wdata, 8'h5c);
    chk({sfr_addr[6:0], sfr_write}, {7'h10, 1'b1});
    rdc(ACC_INDIRECT, 16'h0090, 8'h3c);
    acc(ACC_STACK, 16'h00a0, 1'b1, 8'h4b);
    rdc(ACC_INDIRECT, 16'h00a0, 8'h4b);
    acc(ACC_EXT_POINTER, 16'h02ff, 1'b1, 8'h77);
    rdc(ACC_EXT_POINTER, 16'h02ff, 8'h77);
    acc(ACC_EXT_INDEX, 16'h0020, 1'b1, 8'h66);
    rdc(ACC_EXT_POINTER, 16'h0020, 8'h66);
    acc(ACC_EXT_POINTER, 16'h1234, 1'b1, 8'h5e);
    chk(mem_model.mem[16'h1234], 8'h5e);
    rdc(ACC_EXT_POINTER, 16'h1234, 8'h5e);
    acc(ACC_DIRECT, 16'h008e, 1'b1, 8'hff);
    rdc(ACC_DIRECT, 16'h008e, 8'h03);
    chk(aux_memory_control, 8'h03);
    repeat (2) @(negedge clk);
    chk({7'h00, latch_strobe}, 8'h00);
    code_move_active = 1'b1;
    repeat (2) toggles;
    code_move_active = 1'b0;
    acc(ACC_EXT_POINTER, 16'h02ff, 1'b1, 8'h11);
    chk(mem_model.mem[16'h02ff], 8'h11);
    acc(ACC_EXT_INDEX, 16'h0044, 1'b1, 8'hc3);
    chk(mem_model.mem[16'h0044], 8'hc3);
    rdc(ACC_EXT_INDEX, 16'h0044, 8'hc3);
    acc(ACC_DIRECT, 16'h008e, 1'b1, 8'h00);
    rdc(ACC_EXT_POINTER, 16'h02ff, 8'h77);
    end_of_test;
  end
  // Watchdog: the whole sequence needs well under a thousand clocks
  initial begin
    #100000;
    err_count++;
    end_of_test;
  end
endmodule
